// >>> core/seq_alert_map.vh
`ifndef SEQ_ALERT_MAP_VH
`define SEQ_ALERT_MAP_VH

// register offsets
`define ADDR_PIN_CONFIG        8'h05
`define ADDR_GPIO_DIRECTION    8'h07
`define ADDR_SCAN_CONTROL      8'h10
`define ADDR_MANUAL_CHANNEL    8'h11
`define ADDR_AUTO_SCAN_MASK    8'h12
`define ADDR_ALERT_CH_MASK     8'h14
`define ADDR_ALERT_FUNCTION    8'h16
`define ADDR_ALERT_PIN_CONFIG  8'h17
`define ADDR_EVENT_FLAGS       8'h18

// writable-bit masks, reserved bits are zero here
`define MASK_SCAN_CONTROL      8'h13
`define MASK_MANUAL_CHANNEL    8'hF0
`define MASK_ALERT_FUNCTION    8'h01
`define MASK_ALERT_PIN_CONFIG  8'hF3

// field positions
`define SCAN_GO_BIT            4
`define SCAN_MODE_LSB          0
`define MANUAL_ID_LSB          4
`define ALERT_CRC_BIT          0
`define ALERT_PIN_LSB          4
`define ALERT_LOGIC_LSB        0

// scan mode encodings
`define MODE_MANUAL            2'h0
`define MODE_AUTO              2'h1
`define MODE_ON_THE_FLY        2'h2
`define MODE_RESERVED          2'h3

// alert output styles
`define ALERT_ACTIVE_LOW       2'h0
`define ALERT_ACTIVE_HIGH      2'h1
`define ALERT_PULSE_LOW        2'h2
`define ALERT_PULSE_HIGH       2'h3

// reset values
`define RESET_REG              8'h00

`endif

// >>> core/alert_router.v
`timescale 1ns/1ps
`include "seq_alert_map.vh"

module alert_router #(
    parameter CHANNELS = 8
) (
    // clock and reset
    input  wire                clk,
    input  wire                rst,
    // alert source and routing setup
    input  wire                alert_in,
    input  wire [3:0]          pin_index,
    input  wire [1:0]          logic_style,
    input  wire [CHANNELS-1:0] pin_is_gpio,
    input  wire [CHANNELS-1:0] gpio_is_output,
    // routed result
    output reg  [CHANNELS-1:0] route_sel_q,
    output reg                 route_level_q
);

    reg  alert_prev_q;
    wire alert_rise;
    reg  level_d;
    reg  [CHANNELS-1:0] sel_d;
    integer i;

    assign alert_rise = alert_in & ~alert_prev_q;

    // channel takes the alert only when it is a gpio set as output
    always @* begin
        sel_d = {CHANNELS{1'b0}};
        for (i = 0; i < CHANNELS; i = i + 1) begin
            if (pin_index == i[3:0] && pin_is_gpio[i] && gpio_is_output[i]) begin
                sel_d[i] = 1'b1; // RULE11
            end
        end
    end

    // pulsed styles emit one cycle per rising alert
    always @* begin
        case (logic_style)
            `ALERT_ACTIVE_LOW:  level_d = ~alert_in;
            `ALERT_ACTIVE_HIGH: level_d = alert_in;
            `ALERT_PULSE_LOW:   level_d = ~alert_rise;
            `ALERT_PULSE_HIGH:  level_d = alert_rise;
            default:            level_d = alert_in;
        endcase
    end

    // registered outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_prev_q  <= 1'b0;
            route_sel_q   <= {CHANNELS{1'b0}};
            route_level_q <= 1'b0;
        end else begin
            alert_prev_q  <= alert_in;
            route_sel_q   <= sel_d; // RULE9
            route_level_q <= level_d;
        end
    end

endmodule // alert_router

// >>> core/channel_sequencer_alert_select.v
// Overview of operation
// RULE1: writing one to scan_go scans enabled channels ascending; zero stops it
// RULE2: scan_go acts only while scan_mode_field selects automatic (01b)
// RULE3: scan_mode_field bits 1-0: 00b manual, 01b auto, 10b on-the-fly, 11b reserved
// RULE4: manual mode converts the channel held in manual_channel_id next
// RULE5: manual ids 0-7 pick analog_input_n 0-7; top bit set is reserved
// RULE6: host picks only analog-configured channels for valid manual results
// RULE7: each auto_scan_channel_mask bit includes its channel in the scan
// RULE8: alert_channel_mask bits let event flags drive the internal alert
// RULE9: internal alert is routable onto the chosen digital output channel
// RULE10: manual, auto-scan and alert mask registers reset to zero
// RULE11: alert routing field bits 7-4 names a channel that must be digital output
// RULE12: pin config bit one makes a gpio, zero keeps an analog input
// RULE13: event flag bit reads one when its window comparator saw an event
// RULE14: reserved bits read zero and ignore writes
// RULE15: auto scan wraps from highest enabled to lowest enabled channel
`timescale 1ns/1ps
`include "seq_alert_map.vh"

module channel_sequencer_alert_select #(
    parameter CHANNELS = 8
) (
    // clock and reset
    input  wire                clk,
    input  wire                rst,
    // register port from the serial frame engine
    input  wire                reg_wr_en,
    input  wire                reg_rd_en,
    input  wire [7:0]          reg_addr,
    input  wire [7:0]          reg_wdata,
    output reg  [7:0]          reg_rdata_q,
    output reg                 reg_rvalid_q,
    // conversion engine
    input  wire                conv_done,
    input  wire [3:0]          otf_channel,
    output reg  [2:0]          conv_channel_q,
    output reg                 conv_channel_valid_q,
    output reg                 conv_channel_analog_q,
    output reg                 scan_active_q,
    output reg  [1:0]          scan_mode_q,
    // window comparator status
    input  wire [CHANNELS-1:0] event_flags,
    input  wire                crc_in_error,
    // alert and channel configuration
    output reg                 alert_internal_q,
    output wire [CHANNELS-1:0] alert_pin_sel_q,
    output wire                alert_pin_level_q,
    output reg  [CHANNELS-1:0] pin_is_gpio_q,
    output reg  [CHANNELS-1:0] gpio_is_output_q
);

    // lowest enabled channel of a mask, zero when none
    function [2:0] first_channel;
        input [7:0] mask;
        integer k;
        reg     found;
        begin
            first_channel = 3'h0;
            found = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (!found && mask[k]) begin
                    first_channel = k[2:0];
                    found = 1'b1;
                end
            end
        end
    endfunction

    // next enabled channel above cur, wrapping to the lowest
    function [2:0] next_channel;
        input [2:0] cur;
        input [7:0] mask;
        integer k;
        reg     found;
        begin
            next_channel = first_channel(mask); // RULE15
            found = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (!found && k > cur && mask[k]) begin
                    next_channel = k[2:0]; // RULE1
                    found = 1'b1;
                end
            end
        end
    endfunction

    // masked register write: reserved bits held at zero
    function [7:0] masked_write;
        input [7:0] data;
        input [7:0] mask;
        begin
            masked_write = data & mask; // RULE14
        end
    endfunction

    localparam ST_IDLE = 3'h1;
    localparam ST_LOAD = 3'h2;
    localparam ST_RUN  = 3'h4;

    // register storage
    reg [7:0] pin_cfg_q;
    reg [7:0] gpio_dir_q;
    reg [7:0] scan_ctl_q;
    reg [7:0] manual_sel_q;
    reg [7:0] auto_mask_q;
    reg [7:0] alert_mask_q;
    reg [7:0] alert_func_q;
    reg [7:0] alert_pin_cfg_q;

    // sequencer state
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [2:0] auto_chan_q;
    reg [2:0] auto_chan_d;
    reg [2:0] chan_d;
    reg       chan_valid_d;
    reg [7:0] rdata_d;

    wire [1:0] mode;
    wire       go_effective;
    wire [3:0] manual_id;
    wire       alert_d;

    assign mode         = scan_ctl_q[`SCAN_MODE_LSB +: 2];
    assign manual_id    = manual_sel_q[`MANUAL_ID_LSB +: 4];
    // a stored go bit is ignored in any other mode
    assign go_effective = scan_ctl_q[`SCAN_GO_BIT] && (mode == `MODE_AUTO); // RULE2

    // register writes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_cfg_q       <= `RESET_REG;
            gpio_dir_q      <= `RESET_REG;
            scan_ctl_q      <= `RESET_REG;
            manual_sel_q    <= `RESET_REG; // RULE10
            auto_mask_q     <= `RESET_REG; // RULE10
            alert_mask_q    <= `RESET_REG; // RULE10
            alert_func_q    <= `RESET_REG;
            alert_pin_cfg_q <= `RESET_REG;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `ADDR_PIN_CONFIG: begin
                    pin_cfg_q <= reg_wdata; // RULE12
                end
                `ADDR_GPIO_DIRECTION: begin
                    gpio_dir_q <= reg_wdata;
                end
                `ADDR_SCAN_CONTROL: begin
                    scan_ctl_q <= masked_write(reg_wdata, `MASK_SCAN_CONTROL); // RULE14
                end
                `ADDR_MANUAL_CHANNEL: begin
                    manual_sel_q <= masked_write(reg_wdata, `MASK_MANUAL_CHANNEL); // RULE14
                end
                `ADDR_AUTO_SCAN_MASK: begin
                    auto_mask_q <= reg_wdata; // RULE7
                end
                `ADDR_ALERT_CH_MASK: begin
                    alert_mask_q <= reg_wdata; // RULE8
                end
                `ADDR_ALERT_FUNCTION: begin
                    alert_func_q <= masked_write(reg_wdata, `MASK_ALERT_FUNCTION);
                end
                `ADDR_ALERT_PIN_CONFIG: begin
                    alert_pin_cfg_q <= masked_write(reg_wdata, `MASK_ALERT_PIN_CONFIG); // RULE11
                end
                default: begin
                    pin_cfg_q <= pin_cfg_q; // unmapped writes vanish
                end
            endcase
        end
    end

    // read mux, unmapped addresses answer zero
    always @* begin
        case (reg_addr)
            `ADDR_PIN_CONFIG:       rdata_d = pin_cfg_q;
            `ADDR_GPIO_DIRECTION:   rdata_d = gpio_dir_q;
            `ADDR_SCAN_CONTROL:     rdata_d = scan_ctl_q;
            `ADDR_MANUAL_CHANNEL:   rdata_d = manual_sel_q;
            `ADDR_AUTO_SCAN_MASK:   rdata_d = auto_mask_q;
            `ADDR_ALERT_CH_MASK:    rdata_d = alert_mask_q;
            `ADDR_ALERT_FUNCTION:   rdata_d = alert_func_q;
            `ADDR_ALERT_PIN_CONFIG: rdata_d = alert_pin_cfg_q;
            `ADDR_EVENT_FLAGS:      rdata_d = event_flags; // RULE13
            default:                rdata_d = 8'h00;
        endcase
    end

    // read data register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

    // auto scan state machine; loads lowest enabled channel on start
    always @* begin
        state_d     = state_q;
        auto_chan_d = auto_chan_q;
        case (state_q)
            ST_IDLE: begin
                if (go_effective) begin
                    state_d = ST_LOAD; // RULE1
                end
            end
            ST_LOAD: begin
                auto_chan_d = first_channel(auto_mask_q); // RULE1
                state_d     = go_effective ? ST_RUN : ST_IDLE;
            end
            ST_RUN: begin
                if (!go_effective) begin
                    state_d = ST_IDLE; // RULE1
                end else if (conv_done) begin
                    auto_chan_d = next_channel(auto_chan_q, auto_mask_q); // RULE15
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // channel offered to the converter for its next conversion
    always @* begin
        chan_d       = 3'h0;
        chan_valid_d = 1'b0;
        case (mode)
            `MODE_MANUAL: begin
                chan_d       = manual_id[2:0]; // RULE4
                chan_valid_d = ~manual_id[3]; // RULE5
            end
            `MODE_AUTO: begin
                chan_d       = auto_chan_q;
                // a channel dropped from the mask mid-scan is not offered
                chan_valid_d = (state_q == ST_RUN) && auto_mask_q[auto_chan_q]; // RULE7
            end
            `MODE_ON_THE_FLY: begin
                chan_d       = otf_channel[2:0];
                chan_valid_d = ~otf_channel[3];
            end
            default: begin
                chan_d       = 3'h0; // RULE3
                chan_valid_d = 1'b0;
            end
        endcase
    end

    // internal alert: masked event flags plus optional crc error
    assign alert_d = |(event_flags & alert_mask_q[CHANNELS-1:0]) // RULE8
                   | (crc_in_error & alert_func_q[`ALERT_CRC_BIT]);

    // sequencer and status registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q               <= ST_IDLE;
            auto_chan_q           <= 3'h0;
            conv_channel_q        <= 3'h0;
            conv_channel_valid_q  <= 1'b0;
            conv_channel_analog_q <= 1'b0;
            scan_active_q         <= 1'b0;
            scan_mode_q           <= `MODE_MANUAL;
            alert_internal_q      <= 1'b0;
            pin_is_gpio_q         <= {CHANNELS{1'b0}};
            gpio_is_output_q      <= {CHANNELS{1'b0}};
        end else begin
            state_q               <= state_d;
            auto_chan_q           <= auto_chan_d;
            conv_channel_q        <= chan_d;
            conv_channel_valid_q  <= chan_valid_d;
            // result only trustworthy when the pin is analog
            conv_channel_analog_q <= chan_valid_d & ~pin_cfg_q[chan_d]; // RULE6
            scan_active_q         <= (state_d == ST_RUN);
            scan_mode_q           <= mode; // RULE3
            alert_internal_q      <= alert_d; // RULE8
            pin_is_gpio_q         <= pin_cfg_q[CHANNELS-1:0]; // RULE12
            gpio_is_output_q      <= gpio_dir_q[CHANNELS-1:0];
        end
    end

    // alert routing onto a digital output channel
    alert_router #(
        .CHANNELS (CHANNELS)
    ) u_alert_router (
        .clk            (clk),
        .rst            (rst),
        .alert_in       (alert_internal_q),
        .pin_index      (alert_pin_cfg_q[`ALERT_PIN_LSB +: 4]),
        .logic_style    (alert_pin_cfg_q[`ALERT_LOGIC_LSB +: 2]),
        .pin_is_gpio    (pin_is_gpio_q),
        .gpio_is_output (gpio_is_output_q),
        .route_sel_q    (alert_pin_sel_q), // RULE9
        .route_level_q  (alert_pin_level_q)
    );

endmodule // channel_sequencer_alert_select

// >>> dv/channel_sequencer_alert_select_properties.sv
`timescale 1ns/1ps
module seq_alert_checker #(
    parameter CHANNELS = 8
) (
    // clock and reset
    input wire                clk,
    input wire                rst,
    // register port
    input wire                reg_wr_en,
    input wire                reg_rd_en,
    input wire [7:0]          reg_addr,
    input wire [7:0]          reg_wdata,
    input wire                reg_rvalid_q,
    // sequencer and alert
    input wire                conv_done,
    input wire [2:0]          conv_channel_q,
    input wire                conv_channel_valid_q,
    input wire                scan_active_q,
    input wire [CHANNELS-1:0] event_flags,
    input wire                crc_in_error,
    input wire                alert_internal_q
);
    reg [7:0] sc_q;
    reg [7:0] mc_q;
    reg [7:0] sm_q;
    reg [7:0] am_q;
    reg       fs_q;
    // mirror of the writable fields, so no internal probes are needed
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sc_q <= 8'h00;
            mc_q <= 8'h00;
            sm_q <= 8'h00;
            am_q <= 8'h00;
            fs_q <= 1'b0;
        end else if (reg_wr_en) begin
            case (reg_addr)
                8'h10: sc_q <= reg_wdata & 8'h13;
                8'h11: mc_q <= reg_wdata & 8'hF0;
                8'h12: sm_q <= reg_wdata;
                8'h14: am_q <= reg_wdata;
                8'h16: fs_q <= reg_wdata[0];
                default: ;
            endcase
        end
    end
    // next enabled channel above cur, wrapping; smallest offset wins
    function [2:0] nxt(input [7:0] m, input [2:0] c);
        integer i;
        begin
            nxt = c;
            for (i = 7; i >= 1; i = i - 1)
                if (m[(c + i) % 8]) nxt = (c + i) % 8;
        end
    endfunction
    wire [2:0] nxt_ch    = nxt(sm_q, conv_channel_q);
    wire       alert_src = |(event_flags & am_q[CHANNELS-1:0]) | (crc_in_error & fs_q);

    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // manual id and mode held long enough for the channel to settle
    sequence s_manual_settled;
        ($stable(mc_q) && sc_q[1:0] == 2'h0) [*3];
    endsequence
    sequence s_reserved_mode;
        (sc_q[1:0] == 2'h3) [*3];
    endsequence

    a_read_strobe: assert property (reg_rvalid_q == $past(reg_rd_en))
        else $error("read valid not one cycle after strobe");
    a_alert_mask: assert property (alert_internal_q == $past(alert_src))
        else $error("alert does not follow masked flags");
    a_start_auto: assert property ($rose(scan_active_q) |-> $past(sc_q, 2) == 8'h11)
        else $error("scan started outside auto mode");
    a_stop_scan: assert property (sc_q != 8'h11 |-> ##2 !scan_active_q)
        else $error("scan did not stop");
    // active rises one cycle ahead of the first offered channel
    a_scan_enabled: assert property (scan_active_q && sm_q != 8'h00 |->
        ##1 conv_channel_valid_q && sm_q[conv_channel_q])
        else $error("scan on a disabled channel");
    a_ascend_wrap: assert property (scan_active_q && conv_done |->
        ##2 conv_channel_q == $past(nxt_ch, 2))
        else $error("scan did not step to next enabled channel");
    a_manual_chan: assert property (s_manual_settled |->
        conv_channel_valid_q == !mc_q[7] && (mc_q[7] || conv_channel_q == mc_q[6:4]))
        else $error("manual channel mismatch");
    a_reserved_mode: assert property (s_reserved_mode |-> !conv_channel_valid_q)
        else $error("reserved mode gave a valid channel");
endmodule // seq_alert_checker

bind channel_sequencer_alert_select seq_alert_checker #(.CHANNELS(CHANNELS)) u_chk (
    .clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rvalid_q, .conv_done,
    .conv_channel_q, .conv_channel_valid_q, .scan_active_q, .event_flags, .crc_in_error, .alert_internal_q
);

// >>> dv/reg_host_model.sv
`timescale 1ns/1ps
module reg_host_model (
    // clock
    input  wire       clk,
    // register port toward the device
    output logic       reg_wr_en,
    output logic       reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input  wire  [7:0] reg_rdata_q,
    input  wire        reg_rvalid_q
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // one-cycle strobe; released lines are inverted so stale values never match
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // data is taken only while the valid pulse stands
    task rd(input [7:0] a, output [7:0] d);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        d = reg_rvalid_q ? reg_rdata_q : 8'hXX;
    endtask
endmodule // reg_host_model

// >>> dv/tb_channel_sequencer_alert_select.sv
`timescale 1ns/1ps
module tb_channel_sequencer_alert_select;
    logic       clk, rst, conv_done, crc_in_error;
    logic [3:0] otf_channel;
    logic [7:0] event_flags, d;
    wire        wr_en, rd_en, rvalid, valid, analog, active, alert, level;
    wire  [7:0] addr, wdata, rdata, sel, gpio, gout;
    wire  [2:0] chan;
    wire  [1:0] smode;
    integer     fail_count = 0, compares = 0, i;
    logic [7:0] ta [0:8] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h16, 8'h3F, 8'h05, 8'h07, 8'h17};
    logic [7:0] te [0:8] = '{8'h13, 8'hF0, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'hFF, 8'hFF, 8'hF3};

    reg_host_model host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid));
    channel_sequencer_alert_select #(.CHANNELS(8)) dut (.clk(clk), .rst(rst), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
        .conv_done(conv_done), .otf_channel(otf_channel), .conv_channel_q(chan), .conv_channel_valid_q(valid),
        .conv_channel_analog_q(analog), .scan_active_q(active), .scan_mode_q(smode), .event_flags(event_flags),
        .crc_in_error(crc_in_error), .alert_internal_q(alert), .alert_pin_sel_q(sel),
        .alert_pin_level_q(level), .pin_is_gpio_q(gpio), .gpio_is_output_q(gout));

    // 50 MHz clock
    always #10 clk = ~clk;

    task chk(input string n, input [7:0] e, input [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        host.rd(a, d);
        chk("rdata", e, d);
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // one converter completion pulse
    task pulse;
        @(negedge clk) conv_done = 1'b1;
        @(negedge clk) conv_done = 1'b0;
    endtask
    task results;
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fail_count++;
        results;
    end

    initial begin
        clk = 0; rst = 1; conv_done = 0; crc_in_error = 0;
        otf_channel = 4'h0; event_flags = 8'h00;
        cyc(2);
        rst = 0;
        // idle alert with the active-low default style drives the pin high
        cyc(1);
        chk("level", 8'h01, level);
        // reset values, then reserved bits and an unmapped address
        for (i = 0; i < 9; i++) begin
            rchk(ta[i], 8'h00);
            host.wr(ta[i], 8'hFF);
            rchk(ta[i], te[i]);
        end
        chk("valid", 8'h00, valid);
        for (i = 0; i < 9; i++) host.wr(ta[i], 8'h00);
        event_flags = 8'hA5;
        rchk(8'h18, 8'hA5);
        host.wr(8'h18, 8'h00);
        rchk(8'h18, 8'hA5);
        event_flags = 8'h00;
        // manual ids 0-7 and one reserved id
        for (i = 0; i < 9; i++) begin
            host.wr(8'h11, i << 4);
            cyc(3);
            if (i < 8) chk("channel", i, chan);
            chk("valid", i < 8, valid);
        end
        host.wr(8'h05, 8'h04);
        host.wr(8'h11, 8'h20);
        cyc(3);
        chk("analog", 8'h00, analog);
        host.wr(8'h11, 8'h30);
        cyc(3);
        chk("analog", 8'h01, analog);
        // on-the-fly
        otf_channel = 4'h6;
        host.wr(8'h10, 8'h02);
        cyc(3);
        chk("channel", 8'h06, chan);
        chk("mode", 8'h02, smode);
        // auto scan over channels 1 and 3
        host.wr(8'h12, 8'h0A);
        host.wr(8'h10, 8'h11);
        cyc(4);
        chk("active", 8'h01, active);
        chk("channel", 8'h01, chan);
        pulse;
        cyc(2);
        chk("channel", 8'h03, chan);
        pulse;
        cyc(2);
        chk("channel", 8'h01, chan);
        host.wr(8'h10, 8'h01);
        cyc(3);
        chk("active", 8'h00, active);
        host.wr(8'h10, 8'h10);
        cyc(4);
        chk("active", 8'h00, active);
        // alert through channel 3 as active-high output
        host.wr(8'h05, 8'h08);
        host.wr(8'h07, 8'h08);
        host.wr(8'h17, 8'h31);
        host.wr(8'h14, 8'h04);
        event_flags = 8'h02;
        cyc(3);
        chk("alert", 8'h00, alert);
        event_flags = 8'h04;
        cyc(3);
        chk("alert", 8'h01, alert);
        chk("sel", 8'h08, sel);
        chk("level", 8'h01, level);
        chk("gpio", 8'h08, gpio);
        chk("gpio_out", 8'h08, gout);
        // active-low, then one pulse per rising alert in pulsed-high style
        host.wr(8'h17, 8'h30);
        cyc(1);
        chk("level", 8'h00, level);
        event_flags = 8'h00;
        host.wr(8'h17, 8'h33);
        cyc(2);
        event_flags = 8'h04;
        cyc(2);
        chk("level", 8'h01, level);
        cyc(1);
        chk("level", 8'h00, level);
        results;
    end
endmodule // tb_channel_sequencer_alert_select
